// ---- aic_defines.svh ----
/*
 Offsets, page codes, reset values and timing counts of the analog
 input conditioning block. Assumes inclusion by its bare name.
*/
`ifndef AIC_DEFINES_SVH
`define AIC_DEFINES_SVH
`define AIC_OFF_CTRL   8'h00
`define AIC_OFF_FUNC   8'h04
`define AIC_OFF_TYPE   8'h08
`define AIC_OFF_MINSPD 8'h0C
`define AIC_OFF_MAXSPD 8'h10
`define AIC_OFF_FWDLIM 8'h14
`define AIC_OFF_REVLIM 8'h18
`define AIC_OFF_RAMP   8'h1C
`define AIC_OFF_SPDREF 8'h50
`define AIC_OFF_STAT   8'h54
`define AIC_PAGE_OFS   4'h2
`define AIC_PAGE_GAIN  4'h3
`define AIC_PAGE_VAL   4'h4
`define AIC_FULL_SCALE 16'sd10000
`define AIC_LIVE_ZERO  16'sd2000
`define AIC_GAIN_UNIT  16'sd1000
`define AIC_GAIN_MAX   14'd9999
`define AIC_RST_GAIN   32'h0000_03E8
`define AIC_RST_MAXSPD 32'h0000_0708
`define AIC_RST_LIM    32'h0000_2710
`define AIC_RST_RAMP   32'h0000_0001
`define AIC_TICK_US    1000
`define AIC_CLK_MHZ    25
`define AIC_FN_SPEED   3'h0
`define AIC_FN_NORAMP  3'h1
`define AIC_FN_TORQUE  3'h2
`define AIC_FN_PID     3'h3
`define AIC_FN_PTC     3'h4
`define AIC_FN_PLC     3'h7
`define AIC_TY_INV     3'h2
`define AIC_TY_LIVE    3'h1
`define AIC_TY_LINV    3'h3
`define AIC_TY_BIP     3'h4
`define AIC_RESP_OK    2'h0
`define AIC_RESP_ERR   2'h2
`endif

// ---- aic_pkg.sv ----
/*
 Types of the analog input conditioning block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package aic_pkg;
	typedef logic signed [15:0] aic_pct_t;
	typedef logic signed [19:0] aic_wide_t;
	typedef logic [2:0] aic_code_t;
endpackage

// ---- aic_core.sv ----
/*
 Analog input conditioning: four converted samples get signal-type mapping,
 offset, gain and saturation, then are routed by a per-input function code.
 Assumes samples arrive from another domain (synchronised here), in units of
 0.01 % of full scale, and an AXI4-Lite master on clk.
 // Function
 // (RULE1) Each input shows a read-only signed value, minus to plus 100 percent.
 // (RULE2) Value is sample plus offset, then the sum times gain.
 // (RULE3) Dead zone affects speed-reference inputs only; 1 enables, 0 disables.
 // (RULE4) Dead zone off: minimum input maps directly to minimum speed.
 // (RULE5) Dead zone on: reference held at minimum speed over a low input region.
 // (RULE6) Bipolar inputs two and four: negative input reverses direction.
 // (RULE7) Function code: speed, no-ramp, torque, process, PTC, unused, PLC.
 // (RULE8) Input four treats function code 4 as unused.
 // (RULE9) Speed reference clamped to min and max speed and ramped.
 // (RULE10) No-ramp reference honoured only in vector mode.
 // (RULE11) Torque function sets both limits; fixed limits ignored.
 // (RULE12) Torque function shows 0 to 200 percent, full input gives 200.
 // (RULE13) Process function feeds PID feedback; full input is 100 percent.
 // (RULE14) Code 7 routes the value to the PLC board.
 // (RULE15) Inputs three and four configurable only with expansion present.
 // (RULE16) Offset percent adds as a share of ten volts before gain.
 // (RULE17) Torque function clips negative values to zero.
 // (RULE18) Signal types 2 and 3 invert the input mapping.
 // (RULE19) Monitored value saturates at plus or minus 100 percent.
*/
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "aic_defines.svh"
module aic_core
	import aic_pkg::*;
#(
	parameter int RAMP_TICK_CYCLES = `AIC_TICK_US * `AIC_CLK_MHZ
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Converted samples and expansion detect, from outside the clock domain.
	input  wire logic [63:0] sampleIn,
	input  wire logic        expansionPresent,
	// AXI4-Lite slave.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Routed results.
	output logic [16:0]      speedRef,
	output logic [15:0]      noRampRef,
	output logic             noRampValid,
	output logic [15:0]      forwardTorqueLimit,
	output logic [15:0]      reverseTorqueLimit,
	output logic [15:0]      pidFeedback,
	output logic             pidValid,
	output logic [15:0]      ptcValue,
	output logic             ptcValid,
	output logic [63:0]      plcValue,
	output logic [3:0]       plcValid
);

	// ==========================================================
	// Synchronisers
	logic [63:0] sampleMeta_reg;
	logic [63:0] sample_reg;
	logic [1:0]  presSync_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sampleMeta_reg <= 64'h0;
			sample_reg     <= 64'h0;
			presSync_reg   <= 2'h0;
		end else begin
			sampleMeta_reg <= sampleIn;
			sample_reg     <= sampleMeta_reg;
			presSync_reg   <= {presSync_reg[0], expansionPresent};
		end
	end
	logic present;
	assign present = presSync_reg[1];

	// ==========================================================
	// Registers
	logic [31:0] ctrl_reg, func_reg, type_reg, minSpd_reg, maxSpd_reg;
	logic [31:0] fwdLim_reg, revLim_reg, ramp_reg;
	logic [31:0] ofs_reg [4];
	logic [31:0] gain_reg [4];
	logic        deadZone, vectorMode, refEnable;
	logic [1:0]  refSel, pidSel;
	assign deadZone   = ctrl_reg[0];
	assign vectorMode = ctrl_reg[1];
	assign refEnable  = ctrl_reg[2];
	assign refSel     = ctrl_reg[5:4];
	assign pidSel     = ctrl_reg[9:8];

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic aic_wide_t lim(input aic_wide_t v, input aic_wide_t lo,
		input aic_wide_t hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ==========================================================
	// AXI4-Lite slave
	logic [7:0]  awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	logic        awHeld_reg, wHeld_reg, doWrite, wHit;
	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready  = !wHeld_reg;
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_reg   <= 1'b0;
			wHeld_reg    <= 1'b0;
			awAddr_reg   <= 8'h0;
			wData_reg    <= 32'h0;
			wStrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AIC_RESP_OK;
		end else begin
			if (s_axi_awvalid && !awHeld_reg) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld_reg) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_reg   <= 1'b0;
				wHeld_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wHit ? `AIC_RESP_OK : `AIC_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic [3:0] wPage;
	logic [1:0] wIdx;
	assign wPage = awAddr_reg[7:4];
	assign wIdx  = awAddr_reg[3:2];
	always_comb begin
		wHit = (awAddr_reg[1:0] == 2'h0) && (wPage == `AIC_PAGE_OFS
			|| wPage == `AIC_PAGE_GAIN || wPage == `AIC_PAGE_VAL);
		case (awAddr_reg)
			`AIC_OFF_CTRL, `AIC_OFF_FUNC, `AIC_OFF_TYPE, `AIC_OFF_MINSPD,
			`AIC_OFF_MAXSPD, `AIC_OFF_FWDLIM, `AIC_OFF_REVLIM, `AIC_OFF_RAMP,
			`AIC_OFF_SPDREF, `AIC_OFF_STAT: wHit = 1'b1;
			default: ;
		endcase
	end

	// Without expansion, fields of inputs three and four keep their value.
	logic [31:0] cfgMask;
	assign cfgMask = present ? 32'hFFFF_FFFF : 32'h0000_00FF; // RULE15
	logic [31:0] funcMask;
	assign funcMask = present ? 32'hFFFF_FFFF : 32'h0000_003F; // RULE15
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg   <= 32'h0;
			func_reg   <= 32'h0;
			type_reg   <= 32'h0;
			minSpd_reg <= 32'h0;
			maxSpd_reg <= `AIC_RST_MAXSPD;
			fwdLim_reg <= `AIC_RST_LIM;
			revLim_reg <= `AIC_RST_LIM;
			ramp_reg   <= `AIC_RST_RAMP;
		end else if (doWrite) begin
			case (awAddr_reg)
				`AIC_OFF_CTRL:   ctrl_reg <= merge(ctrl_reg, wData_reg, wStrb_reg);
				`AIC_OFF_FUNC:   func_reg <= (merge(func_reg, wData_reg, wStrb_reg)
					& funcMask) | (func_reg & ~funcMask); // RULE15
				`AIC_OFF_TYPE:   type_reg <= (merge(type_reg, wData_reg, wStrb_reg)
					& cfgMask) | (type_reg & ~cfgMask); // RULE15
				`AIC_OFF_MINSPD: minSpd_reg <= merge(minSpd_reg, wData_reg, wStrb_reg);
				`AIC_OFF_MAXSPD: maxSpd_reg <= merge(maxSpd_reg, wData_reg, wStrb_reg);
				`AIC_OFF_FWDLIM: fwdLim_reg <= merge(fwdLim_reg, wData_reg, wStrb_reg);
				`AIC_OFF_REVLIM: revLim_reg <= merge(revLim_reg, wData_reg, wStrb_reg);
				`AIC_OFF_RAMP:   ramp_reg <= merge(ramp_reg, wData_reg, wStrb_reg);
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Per-input conditioning
	aic_pct_t  value [4];
	aic_pct_t  valueReg [4];
	aic_code_t fn [4];
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_in
			logic       ok;
			aic_code_t  ty;
			aic_wide_t  raw, live, mapped, sum;
			logic signed [35:0] prod;
			assign ok = (gi < 2) || present; // RULE15
			assign ty = type_reg[4*gi +: 3];
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					ofs_reg[gi]  <= 32'h0;
					gain_reg[gi] <= `AIC_RST_GAIN;
				end else if (doWrite && ok && wIdx == 2'(gi)) begin
					if (wPage == `AIC_PAGE_OFS) begin
						ofs_reg[gi] <= merge(ofs_reg[gi], wData_reg, wStrb_reg);
					end
					if (wPage == `AIC_PAGE_GAIN) begin
						gain_reg[gi] <= merge(gain_reg[gi], wData_reg, wStrb_reg);
					end
				end
			end
			always_comb begin
				raw  = aic_wide_t'($signed(sample_reg[16*gi +: 16]));
				live = (raw - `AIC_LIVE_ZERO) + ((raw - `AIC_LIVE_ZERO) >>> 2);
				unique case (ty)
					`AIC_TY_LIVE: mapped = lim(live, 0, `AIC_FULL_SCALE);
					`AIC_TY_INV:  mapped = `AIC_FULL_SCALE
						- lim(raw, 0, `AIC_FULL_SCALE); // RULE18
					`AIC_TY_LINV: mapped = `AIC_FULL_SCALE
						- lim(live, 0, `AIC_FULL_SCALE); // RULE18
					`AIC_TY_BIP:  mapped = (gi % 2 == 1) ? lim(raw, -`AIC_FULL_SCALE,
						`AIC_FULL_SCALE) : lim(raw, 0, `AIC_FULL_SCALE); // RULE6
					default:      mapped = lim(raw, 0, `AIC_FULL_SCALE);
				endcase
				sum  = mapped + lim(aic_wide_t'($signed(ofs_reg[gi][15:0])),
					-`AIC_FULL_SCALE, `AIC_FULL_SCALE); // RULE2 RULE16
				prod = 36'(sum) * $signed({1'b0, 14'(lim(aic_wide_t'(
					gain_reg[gi][13:0]), 0, aic_wide_t'(`AIC_GAIN_MAX)))}); // RULE2
				value[gi] = 16'(lim(20'(prod / `AIC_GAIN_UNIT),
					-`AIC_FULL_SCALE, `AIC_FULL_SCALE)); // RULE19 RULE1
				fn[gi] = ok ? func_reg[3*gi +: 3] : 3'h5; // RULE7
				if (gi == 3 && fn[gi] == `AIC_FN_PTC) begin
					fn[gi] = 3'h5; // RULE8
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					valueReg[gi] <= 16'sh0;
					plcValue[16*gi +: 16] <= 16'h0;
					plcValid[gi] <= 1'b0;
				end else begin
					valueReg[gi] <= (fn[gi] == `AIC_FN_TORQUE) ? ((value[gi] < 0) ? 16'sh0
						: 16'(value[gi] <<< 1)) : value[gi]; // RULE12 RULE17
					plcValid[gi] <= fn[gi] == `AIC_FN_PLC; // RULE14
					plcValue[16*gi +: 16] <= (fn[gi] == `AIC_FN_PLC) ? value[gi] : 16'h0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Speed reference with dead zone, limits and ramp
	aic_pct_t    sel;
	logic [15:0] mag, minSpd, maxSpd;
	logic [31:0] span;
	aic_wide_t   target, ref_reg;
	assign sel    = value[refSel];
	assign mag    = (sel < 0) ? 16'(-sel) : 16'(sel);
	assign minSpd = minSpd_reg[15:0];
	assign maxSpd = maxSpd_reg[15:0];
	always_comb begin
		if (deadZone) begin
			span = (32'(mag) * 32'(maxSpd)) / 32'(`AIC_FULL_SCALE); // RULE5
		end else begin
			span = 32'(minSpd) + (32'(mag) * 32'(maxSpd - minSpd))
				/ 32'(`AIC_FULL_SCALE); // RULE4
		end
		target = lim(aic_wide_t'(span[18:0]), aic_wide_t'(minSpd),
			aic_wide_t'(maxSpd)); // RULE9
		if (sel < 0) begin
			target = -target; // RULE6
		end
		if (!refEnable || fn[refSel] != `AIC_FN_SPEED) begin
			target = 20'sh0; // RULE3
		end
	end

	logic [31:0] tick_reg;
	logic        tick;
	assign tick = tick_reg == 32'(RAMP_TICK_CYCLES - 1);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_reg <= 32'h0;
		end else begin
			tick_reg <= tick ? 32'h0 : tick_reg + 32'h1;
		end
	end

	aic_wide_t step;
	assign step = aic_wide_t'(ramp_reg[15:0]);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_reg <= 20'sh0;
		end else if (tick) begin
			if (target > ref_reg) begin
				ref_reg <= (target - ref_reg > step) ? ref_reg + step : target; // RULE9
			end else begin
				ref_reg <= (ref_reg - target > step) ? ref_reg - step : target; // RULE9
			end
		end
	end
	assign speedRef = ref_reg[16:0];

	// ==========================================================
	// Torque, PID, no-ramp, PTC routing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			forwardTorqueLimit <= 16'h0;
			reverseTorqueLimit <= 16'h0;
			noRampRef   <= 16'h0;
			noRampValid <= 1'b0;
			pidFeedback <= 16'h0;
			pidValid    <= 1'b0;
			ptcValue    <= 16'h0;
			ptcValid    <= 1'b0;
		end else begin
			forwardTorqueLimit <= fwdLim_reg[15:0];
			reverseTorqueLimit <= revLim_reg[15:0];
			noRampValid <= 1'b0;
			ptcValid    <= 1'b0;
			for (int i = 3; i >= 0; i--) begin
				if (fn[i] == `AIC_FN_TORQUE) begin
					forwardTorqueLimit <= valueReg[i]; // RULE11
					reverseTorqueLimit <= valueReg[i]; // RULE11
				end
				if (fn[i] == `AIC_FN_NORAMP && vectorMode) begin
					noRampRef   <= value[i]; // RULE10
					noRampValid <= 1'b1; // RULE10
				end
				if (fn[i] == `AIC_FN_PTC) begin
					ptcValue <= value[i];
					ptcValid <= 1'b1;
				end
			end
			pidValid    <= fn[pidSel] == `AIC_FN_PID; // RULE13
			pidFeedback <= (fn[pidSel] == `AIC_FN_PID) ? value[pidSel] : 16'h0; // RULE13
		end
	end

	// ==========================================================
	// Read channel
	logic [31:0] rd;
	logic        rHit;
	always_comb begin
		rd   = 32'h0;
		rHit = 1'b1;
		case (s_axi_araddr)
			`AIC_OFF_CTRL:   rd = ctrl_reg;
			`AIC_OFF_FUNC:   rd = func_reg & funcMask; // RULE15
			`AIC_OFF_TYPE:   rd = type_reg & cfgMask; // RULE15
			`AIC_OFF_MINSPD: rd = minSpd_reg;
			`AIC_OFF_MAXSPD: rd = maxSpd_reg;
			`AIC_OFF_FWDLIM: rd = fwdLim_reg;
			`AIC_OFF_REVLIM: rd = revLim_reg;
			`AIC_OFF_RAMP:   rd = ramp_reg;
			`AIC_OFF_SPDREF: rd = 32'(ref_reg);
			`AIC_OFF_STAT:   rd = {30'h0, ref_reg < 0, present};
			default: begin
				rHit = 1'b0;
				if (s_axi_araddr[1:0] == 2'h0 && (!s_axi_araddr[3] || present)) begin // RULE15
					rHit = 1'b1;
					unique case (s_axi_araddr[7:4])
						`AIC_PAGE_OFS:  rd = ofs_reg[s_axi_araddr[3:2]];
						`AIC_PAGE_GAIN: rd = gain_reg[s_axi_araddr[3:2]];
						`AIC_PAGE_VAL:  rd = 32'(valueReg[s_axi_araddr[3:2]]); // RULE1
						default:        rHit = 1'b0;
					endcase
				end
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `AIC_RESP_OK;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rHit ? rd : 32'h0;
			s_axi_rresp  <= rHit ? `AIC_RESP_OK : `AIC_RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ---- aic_core_monitor.sv ----
/*
 Checker of the conditioning core: bus handshakes and routed result ranges.
 Assumes binding to aic_core, one clock domain and an active-low reset.
*/
`timescale 1ns/1ns
module aic_core_monitor (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        expansionPresent,
	// Bus handshakes.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Routed results.
	input wire logic [15:0] noRampRef,
	input wire logic        noRampValid,
	input wire logic [15:0] pidFeedback,
	input wire logic        pidValid,
	input wire logic [63:0] plcValue,
	input wire logic [3:0]  plcValid
);
	logic [3:0] absentCnt;

	// ==========================================================
	// Cycles without the expansion module.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			absentCnt <= 4'h0;
		else if (expansionPresent)
			absentCnt <= 4'h0;
		else if (absentCnt != 4'hF)
			absentCnt <= absentCnt + 4'h1;
	end

	// ==========================================================
	// Properties.
	default clocking mc @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered in one cycle");
	AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer not held");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
	AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer not held");
	AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address accepted");
	AST_PID_RANGE: assert property (pidValid |-> $signed(pidFeedback) <= 16'sh2710
		&& $signed(pidFeedback) >= -16'sh2710) else $error("feedback out of range");
	AST_NORAMP_RANGE: assert property (noRampValid |-> $signed(noRampRef) <= 16'sh2710
		&& $signed(noRampRef) >= -16'sh2710) else $error("no-ramp value out of range");
	AST_PLC_RANGE: assert property (plcValid[0] |-> $signed(plcValue[15:0]) <= 16'sh2710
		&& $signed(plcValue[15:0]) >= -16'sh2710) else $error("board value out of range");
	AST_EXP_GATE: assert property (absentCnt == 4'hF |-> plcValid[3:2] == 2'h0)
		else $error("input three or four routed without expansion");
endmodule

bind aic_core aic_core_monitor aic_core_monitor_i (
	.clk(clk), .reset_n(reset_n), .expansionPresent(expansionPresent),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .noRampRef(noRampRef),
	.noRampValid(noRampValid), .pidFeedback(pidFeedback), .pidValid(pidValid),
	.plcValue(plcValue), .plcValid(plcValid)
);

// ---- aic_sensor_model.sv ----
/*
 Sensors and reference sources wired to the four analog inputs.
 Assumes the bench commands each level and the expansion plug state.
*/
`timescale 1ns/1ns
module aic_sensor_model (
	// Clock.
	input  wire logic        clk,
	// Commanded levels and plug state.
	input  wire logic [63:0] levels,
	input  wire logic        plugged,
	// Converted samples toward the block.
	output logic      [63:0] sampleIn,
	output logic             expansionPresent
);
	// ==========================================================
	// Converter refreshes every cycle; the block resynchronises both.
	always_ff @(posedge clk) begin
		sampleIn         <= levels;
		expansionPresent <= plugged;
	end
endmodule

// ---- analog_input_conditioning_test.sv ----
/*
 Self-checking bench of the conditioning core.
 Assumes the sensor model and the bound checker are compiled beforehand.
*/
`timescale 1ns/1ns
module analog_input_conditioning_test;
	localparam logic [31:0] LO = 32'h0000_FFFF;
	logic clk, reset_n, plugged, expansionPresent, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, noRampValid, pidValid, ptcValid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb, plcValid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [16:0] speedRef;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [15:0] noRampRef, forwardTorqueLimit, reverseTorqueLimit, pidFeedback, ptcValue;
	logic [63:0] levels, sampleIn, plcValue;
	int checked, n_mismatch;

	aic_sensor_model aic_sensor_model_i (.clk(clk), .levels(levels), .plugged(plugged),
		.sampleIn(sampleIn), .expansionPresent(expansionPresent));
	aic_core #(.RAMP_TICK_CYCLES(4)) aic_core_i (.clk(clk), .reset_n(reset_n),
		.sampleIn(sampleIn), .expansionPresent(expansionPresent), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .speedRef(speedRef),
		.noRampRef(noRampRef), .noRampValid(noRampValid), .forwardTorqueLimit(forwardTorqueLimit),
		.reverseTorqueLimit(reverseTorqueLimit), .pidFeedback(pidFeedback), .pidValid(pidValid),
		.ptcValue(ptcValue), .ptcValid(ptcValid), .plcValue(plcValue), .plcValid(plcValid));

	// ==========================================================
	// Shared tasks.
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic settle;
		repeat (8) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awT, wT, bT;
		logic [1:0] r;
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			awT = s_axi_awvalid && s_axi_awready;
			wT = s_axi_wvalid && s_axi_wready;
			bT = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (awT) s_axi_awvalid <= 1'b0;
			if (wT) s_axi_wvalid <= 1'b0;
			n++;
		end while (bT !== 1'b1 && n < 50);
		if (bT !== 1'b1) n_mismatch++;
		s_axi_bready <= 1'b0;
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input logic [1:0] er);
		logic arT, rT;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			arT = s_axi_arvalid && s_axi_arready;
			rT = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (arT) s_axi_arvalid <= 1'b0;
			n++;
		end while (rT !== 1'b1 && n < 50);
		if (rT !== 1'b1) n_mismatch++;
		s_axi_rready <= 1'b0;
		chk({30'h0, r}, {30'h0, er});
		chk(d & m, e);
	endtask

	task automatic setIn(input int i, input logic [15:0] v);
		@(posedge clk);
		levels[16*i +: 16] <= v;
		settle();
	endtask

	task automatic waitSpeed(input logic [16:0] e);
		int n;
		n = 0;
		while (speedRef !== e && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0, speedRef}, {15'h0, e});
	endtask

	// ==========================================================
	// Scenarios.
	task automatic testValue;
		rd(8'h30, '1, 32'h0000_03E8, 2'h0);
		setIn(0, 16'h1388);
		wr(8'h20, 32'hFFFF_E4A8, 2'h0);
		rd(8'h40, LO, 32'h0000_F830, 2'h0);
		wr(8'h20, 32'h0, 2'h0);
		wr(8'h30, 32'h0000_07D0, 2'h0);
		setIn(0, 16'h1F40);
		rd(8'h40, LO, 32'h0000_2710, 2'h0);
		wr(8'h20, 32'hFFFF_D8F0, 2'h0);
		setIn(0, 16'h07D0);
		rd(8'h40, LO, 32'h0000_D8F0, 2'h0);
		wr(8'h40, 32'h0, 2'h0);
		rd(8'h40, LO, 32'h0000_D8F0, 2'h0);
		wr(8'h20, 32'h0, 2'h0);
		wr(8'h30, 32'h0000_03E8, 2'h0);
	endtask

	task automatic testFunc;
		logic [31:0] lim;
		setIn(0, 16'h0BB8);
		for (int c = 0; c < 8; c++) begin
			wr(8'h04, 32'(c), 2'h0);
			settle();
			lim = (c == 2) ? 32'h0000_1770 : 32'h0000_2710;
			chk({31'h0, pidValid}, 32'(c == 3));
			chk({31'h0, ptcValid}, 32'(c == 4));
			chk({31'h0, plcValid[0]}, 32'(c == 7));
			if (c == 4) chk({16'h0, ptcValue}, 32'h0000_0BB8);
			if (c == 7) chk({16'h0, plcValue[15:0]}, 32'h0000_0BB8);
			chk({31'h0, noRampValid}, 32'h0);
			chk({16'h0, forwardTorqueLimit}, lim);
			chk({16'h0, reverseTorqueLimit}, lim);
			rd(8'h40, LO, (c == 2) ? lim : 32'h0000_0BB8, 2'h0);
		end
		wr(8'h04, 32'h3, 2'h0);
		setIn(0, 16'h2710);
		chk({16'h0, pidFeedback}, 32'h0000_2710);
		wr(8'h00, 32'h2, 2'h0);
		wr(8'h04, 32'h1, 2'h0);
		settle();
		chk({15'h0, noRampValid, noRampRef}, 32'h0001_2710);
		wr(8'h04, 32'h2, 2'h0);
		settle();
		chk({16'h0, forwardTorqueLimit}, 32'h0000_4E20);
		wr(8'h20, 32'hFFFF_EC78, 2'h0);
		setIn(0, 16'h07D0);
		chk({16'h0, reverseTorqueLimit}, 32'h0);
		wr(8'h20, 32'h0, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
	endtask

	task automatic testGate;
		wr(8'h04, 32'h0000_01C0, 2'h0);
		settle();
		chk({31'h0, plcValid[2]}, 32'h0);
		rd(8'h28, 32'h0, 32'h0, 2'h2);
		rd(8'h58, 32'h0, 32'h0, 2'h2);
		wr(8'h58, 32'h0, 2'h2);
		@(posedge clk);
		plugged <= 1'b1;
		settle();
		wr(8'h04, 32'h0000_01C0, 2'h0);
		settle();
		chk({31'h0, plcValid[2]}, 32'h1);
		wr(8'h04, 32'h0000_0800, 2'h0);
		setIn(3, 16'h0BB8);
		chk({27'h0, ptcValid, plcValid}, 32'h0);
		wr(8'h04, 32'h0, 2'h0);
	endtask

	task automatic testSpeed;
		wr(8'h0C, 32'h0000_012C, 2'h0);
		wr(8'h1C, 32'h0000_0064, 2'h0);
		wr(8'h00, 32'h4, 2'h0);
		setIn(0, 16'h1388);
		waitSpeed(17'h0041A);
		setIn(0, 16'h03E8);
		waitSpeed(17'h001C2);
		wr(8'h00, 32'h5, 2'h0);
		waitSpeed(17'h0012C);
		setIn(0, 16'h1388);
		waitSpeed(17'h00384);
		wr(8'h00, 32'h4, 2'h0);
		wr(8'h08, 32'h2, 2'h0);
		setIn(0, 16'h07D0);
		waitSpeed(17'h005DC);
		rd(8'h40, LO, 32'h0000_1F40, 2'h0);
		wr(8'h08, 32'h0000_0040, 2'h0);
		setIn(1, 16'hEC78);
		wr(8'h00, 32'h0000_0014, 2'h0);
		waitSpeed(17'h1FBE6);
		rd(8'h54, 32'h2, 32'h2, 2'h0);
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#(40 * 40000);
		n_mismatch++;
		conclude();
	end

	initial begin
		{reset_n, plugged, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		levels = 64'h0;
		checked = 0;
		n_mismatch = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		testValue();
		testFunc();
		testGate();
		testSpeed();
		conclude();
	end
endmodule
